// *** dv/afs_chk.sv ***
`timescale 1ns/100ps
`default_nettype none
module afs_chk (
  // Clock and reset.
  input wire logic       pclk,
  input wire logic       presetn,
  // Control link.
  input wire logic       ctl_req,
  input wire logic       ctl_we,
  input wire logic [7:0] ctl_addr,
  input wire logic [7:0] ctl_wdata,
  input wire logic       ctl_ack,
  input wire logic [7:0] ctl_rdata,
  input wire logic       speaker_shutdown_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////////
  // A command is answered on the next edge and leaves one quiet cycle after.
  sequence s_cmd;
    ctl_req ##1 (ctl_ack && !ctl_req) ##1 !ctl_req;
  endsequence
  sequence s_fault_wr;
    ctl_req && ctl_we && ctl_addr == afs_pkg::FAULT_ADDR;
  endsequence

  a_cmd_handshake: assert property (ctl_req |-> s_cmd)
    else $error("link command not answered in one cycle");
  a_ack_has_cause: assert property (ctl_ack |-> $past(ctl_req))
    else $error("link answer without a request");
  a_no_reserved_addr: assert property (ctl_req |->
      !(ctl_addr inside {[afs_pkg::RSVD_LO_ADDR:afs_pkg::RSVD_HI_ADDR]}))
    else $error("reserved link offset used");
  a_rsvd_read_zero: assert property (ctl_ack && !ctl_we &&
      ctl_addr == afs_pkg::FAULT_ADDR |-> ctl_rdata[7:6] == 2'h0)
    else $error("reserved fault bits read nonzero");
  a_rsvd_write_kept: assert property (s_fault_wr |->
      ctl_wdata[7:6] == 2'h0)
    else $error("reserved fault bits written nonzero");
  a_flag_write_masked: assert property (s_fault_wr |->
      ctl_wdata[3:0] == 4'h0)
    else $error("fault flag bits sent in a write");
  a_cmd_stable: assert property (ctl_ack |->
      $stable(ctl_addr) && $stable(ctl_we))
    else $error("command changed before its answer");
  a_rdata_holds: assert property ($changed(ctl_rdata) |->
      ctl_ack && !ctl_we)
    else $error("link read data changed outside a read answer");

  c_fault_write: cover property (s_fault_wr);
  c_pin_toggle: cover property ($rose(speaker_shutdown_n));
endmodule
`default_nettype wire

// *** dv/amp_fault_status_reg_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module amp_fault_status_reg_bench;
  localparam logic [7:0] FULL = 8'hc0;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        pready;
  logic        pslverr;
  logic        irq_o;
  logic        amp_run_o;
  logic        clock_error_i;
  logic        dc_offset_over_i;
  logic        overtemp_over_i;
  logic [7:0]  paddr;
  logic [7:0]  oc_current_i;
  logic [7:0]  oc_limit_o;
  logic [7:0]  f;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] q;
  logic [3:0]  fault_flags_o;
  int          errors;
  int          cmp_count;

  afs_if afs_link ();
  afs_device #(.OC_FULL_LEVEL(FULL)) i_afs_device (
    .pclk(pclk), .presetn(presetn), .pclk_en(1'b1), .link(afs_link.device),
    .clock_error_i(clock_error_i), .oc_current_i(oc_current_i),
    .dc_offset_over_i(dc_offset_over_i), .overtemp_over_i(overtemp_over_i),
    .amp_run_o(amp_run_o), .oc_limit_o(oc_limit_o),
    .fault_flags_o(fault_flags_o));
  afs_host i_afs_host (
    .pclk(pclk), .presetn(presetn), .pclk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_o(irq_o),
    .link(afs_link.host));
  afs_chk i_afs_chk (
    .pclk(pclk), .presetn(presetn), .ctl_req(afs_link.ctl_req),
    .ctl_we(afs_link.ctl_we), .ctl_addr(afs_link.ctl_addr),
    .ctl_wdata(afs_link.ctl_wdata), .ctl_ack(afs_link.ctl_ack),
    .ctl_rdata(afs_link.ctl_rdata),
    .speaker_shutdown_n(afs_link.speaker_shutdown_n));

  always #5 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////////
  task stop_test;
    if (errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task wait_n(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    // An idle edge keeps the next setup from overwriting this release.
    @(posedge pclk);
  endtask

  // The pause covers the link round trip; only the busy poll ends it.
  task dev(input logic w, input logic [7:0] a, input logic [7:0] d,
           output logic [7:0] r);
    logic [31:0] s;
    apb(1'b1, afs_pkg::H_CMD_ADDR, {15'h0, w, a, d}, s);
    wait_n(3);
    do begin
      apb(1'b0, afs_pkg::H_STAT_ADDR, 32'h0, s);
    end while (s[afs_pkg::STAT_BUSY_BIT] !== 1'b0);
    r = s[7:0];
  endtask

  task pin(input logic v);
    apb(1'b1, afs_pkg::H_PIN_ADDR, {31'h0, v}, q);
    wait_n(6);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task t_reset_values;
    dev(1'b0, afs_pkg::FAULT_ADDR, 8'h00, f);
    chk("fault reg", 32'h0, f);
    chk("oc limit", FULL, oc_limit_o);
    chk("run in shutdown", 32'h0, amp_run_o);
  endtask

  task t_scale;
    logic [7:0] lim;
    for (int s = 0; s < 4; s++) begin
      lim = s == 0 ? FULL : s == 1 ? FULL - (FULL >> 2) :
            s == 2 ? FULL >> 1 : FULL >> 2;
      dev(1'b1, afs_pkg::FAULT_ADDR, {2'b11, s[1:0], 4'hf}, f);
      dev(1'b0, afs_pkg::FAULT_ADDR, 8'h00, f);
      chk("scale read", {2'b00, s[1:0], 4'h0}, f);
      chk("oc limit", lim, oc_limit_o);
    end
  endtask

  task t_clock;
    pin(1'b1);
    chk("run", 32'h1, amp_run_o);
    clock_error_i <= 1'b1;
    wait_n(6);
    dev(1'b0, afs_pkg::FAULT_ADDR, 8'h00, f);
    chk("clock flag", 32'h8, f[3:0]);
    chk("clock flag pin", 32'h8, fault_flags_o);
    chk("run on clock fault", 32'h0, amp_run_o);
    clock_error_i <= 1'b0;
    wait_n(6);
    dev(1'b0, afs_pkg::FAULT_ADDR, 8'h00, f);
    chk("clock flag gone", 32'h0, f[3:0]);
    chk("run resumed", 32'h1, amp_run_o);
  endtask

  // Limit is a quarter scale here, so a current equal to it must not trip.
  task t_oc_boundary;
    oc_current_i <= FULL >> 2;
    wait_n(6);
    dev(1'b0, afs_pkg::FAULT_ADDR, 8'h00, f);
    chk("no trip at limit", 32'h0, f[3:0]);
    oc_current_i <= 8'h00;
  endtask

  task t_latch(input int b);
    case (b)
      0: overtemp_over_i <= 1'b1;
      1: dc_offset_over_i <= 1'b1;
      default: oc_current_i <= (FULL >> 2) + 8'h01;
    endcase
    wait_n(6);
    overtemp_over_i <= 1'b0;
    dc_offset_over_i <= 1'b0;
    oc_current_i <= 8'h00;
    wait_n(6);
    dev(1'b0, afs_pkg::FAULT_ADDR, 8'h00, f);
    chk("latched flag", 32'h1 << b, f[3:0]);
    chk("flag pins", 32'h1 << b, fault_flags_o);
    chk("halted", 32'h0, amp_run_o);
    pin(1'b0);
    pin(1'b1);
    dev(1'b0, afs_pkg::FAULT_ADDR, 8'h00, f);
    chk("flags cleared", 32'h0, f[3:0]);
    chk("flag pins cleared", 32'h0, fault_flags_o);
    chk("run after toggle", 32'h1, amp_run_o);
  endtask

  task t_ctrl;
    apb(1'b1, afs_pkg::H_IMASK_ADDR, 32'h4, q);
    overtemp_over_i <= 1'b1;
    wait_n(6);
    overtemp_over_i <= 1'b0;
    dev(1'b0, afs_pkg::FAULT_ADDR, 8'h00, f);
    wait_n(2);
    chk("fault read irq", 32'h1, irq_o);
    apb(1'b0, afs_pkg::H_ISTAT_ADDR, 32'h0, q);
    apb(1'b1, afs_pkg::H_IMASK_ADDR, 32'h0, q);
    dev(1'b1, afs_pkg::CTRL_ADDR, 8'h00, f);
    chk("run bit cleared", 32'h0, amp_run_o);
    dev(1'b1, afs_pkg::CTRL_ADDR, 8'h01, f);
    wait_n(6);
    dev(1'b0, afs_pkg::FAULT_ADDR, 8'h00, f);
    chk("flags after run bit", 32'h0, f[3:0]);
    chk("run after run bit", 32'h1, amp_run_o);
  endtask

  task t_irq;
    apb(1'b0, afs_pkg::H_ISTAT_ADDR, 32'h0, q);
    apb(1'b1, afs_pkg::H_IMASK_ADDR, 32'h2, q);
    dev(1'b1, afs_pkg::RSVD_LO_ADDR, 8'h00, f);
    wait_n(2);
    chk("refused irq", 32'h1, irq_o);
    chk("no bus error", 32'h0, pslverr);
    apb(1'b0, afs_pkg::H_ISTAT_ADDR, 32'h0, q);
    chk("refused status", 32'h2, q & 32'h2);
    wait_n(2);
    chk("irq after clear", 32'h0, irq_o);
    apb(1'b1, afs_pkg::H_IMASK_ADDR, 32'h0, q);
    dev(1'b1, afs_pkg::RSVD_HI_ADDR, 8'h00, f);
    wait_n(2);
    chk("masked irq", 32'h0, irq_o);
    apb(1'b0, 8'h14, 32'h0, q);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    clock_error_i = 1'b0;
    oc_current_i = 8'h00;
    dc_offset_over_i = 1'b0;
    overtemp_over_i = 1'b0;
    errors = 0;
    cmp_count = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset_values;
    t_scale;
    t_clock;
    t_oc_boundary;
    for (int b = 0; b < 3; b++) t_latch(b);
    t_ctrl;
    t_irq;
    stop_test;
  end

  // The sequence needs under four hundred cycles; this allows 30000, over seventy times that.
  initial begin
    #300000;
    errors++;
    stop_test;
  end
endmodule
`default_nettype wire

// *** logic/afs_device.sv ***
// Function
// - Scale field picks 100, 75, 50, 25 percent
// - Top two bits reserved, read zero
// - Clock fault flag follows clock error
// - Clock fault self-clears, operation resumes
// - Overcurrent above threshold sets latched flag
// - Overcurrent stays until shutdown toggle
// - DC offset excess sets latched flag
// - DC offset stays until shutdown toggle
// - Overtemperature sets latched flag
// - Overtemperature stays until shutdown toggle
// - Host avoids reserved offsets 0x09 to 0x0F
// - Fault register lives at offset 0x08
// - Pin low or control bit clear shuts down
//
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module afs_device #(
  parameter logic [7:0] OC_FULL_LEVEL = 8'hc0
) (
  // Clock and reset.
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       pclk_en,
  // Control port and shutdown pin.
  afs_if.device           link,
  // Analogue detector levels, asynchronous to pclk.
  input  wire logic       clock_error_i,
  input  wire logic [7:0] oc_current_i,
  input  wire logic       dc_offset_over_i,
  input  wire logic       overtemp_over_i,
  // Amplifier state.
  output logic            amp_run_o,
  output logic [7:0]      oc_limit_o,
  output logic [3:0]      fault_flags_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers.

  logic       clk_err_s1_reg;
  logic       clk_err_s2_reg;
  logic       dc_s1_reg;
  logic       dc_s2_reg;
  logic       ot_s1_reg;
  logic       ot_s2_reg;
  logic       sd_s1_reg;
  logic       sd_s2_reg;
  logic [7:0] cur_s1_reg;
  logic [7:0] cur_s2_reg;

  // The current sample is a slow converter output, so a word-wide two-flop
  // stage is accepted; a torn sample only shifts the trip by one sample.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_err_s1_reg <= 1'b0;
      clk_err_s2_reg <= 1'b0;
      dc_s1_reg      <= 1'b0;
      dc_s2_reg      <= 1'b0;
      ot_s1_reg      <= 1'b0;
      ot_s2_reg      <= 1'b0;
      sd_s1_reg      <= 1'b0;
      sd_s2_reg      <= 1'b0;
      cur_s1_reg     <= 8'h00;
      cur_s2_reg     <= 8'h00;
    end else if (pclk_en) begin
      clk_err_s1_reg <= clock_error_i;
      clk_err_s2_reg <= clk_err_s1_reg;
      dc_s1_reg      <= dc_offset_over_i;
      dc_s2_reg      <= dc_s1_reg;
      ot_s1_reg      <= overtemp_over_i;
      ot_s2_reg      <= ot_s1_reg;
      sd_s1_reg      <= link.speaker_shutdown_n;
      sd_s2_reg      <= sd_s1_reg;
      cur_s1_reg     <= oc_current_i;
      cur_s2_reg     <= cur_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register writes.

  logic [1:0] scale_reg;
  logic       run_ctrl_reg;
  logic       wr_fault;
  logic       wr_ctrl;

  assign wr_fault = link.ctl_req && link.ctl_we &&
                    (link.ctl_addr == afs_pkg::FAULT_ADDR);
  assign wr_ctrl  = link.ctl_req && link.ctl_we &&
                    (link.ctl_addr == afs_pkg::CTRL_ADDR);

  // Only the scale field takes write data; reserved and flag bits drop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scale_reg <= afs_pkg::SCALE_RESET;
    end else if (pclk_en && wr_fault) begin
      scale_reg <= link.ctl_wdata[afs_pkg::SCALE_LSB +: 2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_ctrl_reg <= afs_pkg::RUN_RESET;
    end else if (pclk_en && wr_ctrl) begin
      run_ctrl_reg <= link.ctl_wdata[afs_pkg::RUN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Overcurrent trip level.

  logic [7:0] limit_next;
  logic [7:0] limit_reg;

  always_comb begin
    unique case (scale_reg)
      afs_pkg::SCALE_FULL: limit_next = OC_FULL_LEVEL;
      afs_pkg::SCALE_75:   limit_next = OC_FULL_LEVEL - (OC_FULL_LEVEL >> 2);
      afs_pkg::SCALE_50:   limit_next = OC_FULL_LEVEL >> 1;
      afs_pkg::SCALE_25:   limit_next = OC_FULL_LEVEL >> 2;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limit_reg <= OC_FULL_LEVEL;
    end else if (pclk_en) begin
      limit_reg <= limit_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shutdown and recovery.

  logic shutdown;
  logic shut_d_reg;
  logic recover;

  assign shutdown = !sd_s2_reg || !run_ctrl_reg;
  // Leaving shutdown completes the low-then-high toggle.
  assign recover  = shut_d_reg && !shutdown;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shut_d_reg <= 1'b1;
    end else if (pclk_en) begin
      shut_d_reg <= shutdown;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault flags.

  logic clk_fault_reg;
  logic oc_fault_reg;
  logic dc_fault_reg;
  logic ot_fault_reg;
  logic oc_over;

  assign oc_over = cur_s2_reg > limit_reg;

  // The clock flag is a plain level with no latch.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_fault_reg <= 1'b0;
    end else if (pclk_en) begin
      clk_fault_reg <= clk_err_s2_reg;
    end
  end

  // Setting is tested first so that a fault arriving in the recovery cycle
  // is kept rather than wiped by the toggle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oc_fault_reg <= 1'b0;
    end else if (pclk_en) begin
      if (oc_over) begin
        oc_fault_reg <= 1'b1;
      end else if (recover) begin
        oc_fault_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dc_fault_reg <= 1'b0;
    end else if (pclk_en) begin
      if (dc_s2_reg) begin
        dc_fault_reg <= 1'b1;
      end else if (recover) begin
        dc_fault_reg <= 1'b0;
      end
    end
  end

  // A die that is still hot at recovery keeps the flag set; a recovery once the die is cool clears it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ot_fault_reg <= 1'b0;
    end else if (pclk_en) begin
      if (ot_s2_reg) begin
        ot_fault_reg <= 1'b1;
      end else if (recover) begin
        ot_fault_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control port answers.

  logic       ack_reg;
  logic [7:0] rdata_reg;
  logic [7:0] fault_word;

  assign fault_word = {2'h0, scale_reg, clk_fault_reg, oc_fault_reg,
                       dc_fault_reg, ot_fault_reg};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_reg <= 1'b0;
    end else if (pclk_en) begin
      ack_reg <= link.ctl_req;
    end
  end

  // Unmapped offsets read as zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= 8'h00;
    end else if (pclk_en && link.ctl_req && !link.ctl_we) begin
      if (link.ctl_addr == afs_pkg::FAULT_ADDR) begin
        rdata_reg <= fault_word;
      end else if (link.ctl_addr == afs_pkg::CTRL_ADDR) begin
        rdata_reg <= {7'h00, run_ctrl_reg};
      end else begin
        rdata_reg <= 8'h00;
      end
    end
  end

  assign link.ctl_ack   = ack_reg;
  assign link.ctl_rdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Amplifier status outputs.

  logic run_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_reg <= 1'b0;
    end else if (pclk_en) begin
      run_reg <= !shutdown && !clk_err_s2_reg && !oc_fault_reg &&
                 !dc_fault_reg && !ot_fault_reg;
    end
  end

  assign amp_run_o     = run_reg;
  assign oc_limit_o    = limit_reg;
  assign fault_flags_o = fault_word[3:0];

endmodule
`default_nettype wire

// *** logic/afs_host.sv ***
`timescale 1ns/100ps
`default_nettype none
module afs_host (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        pclk_en,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Interrupt.
  output logic             irq_o,
  // Link to the amplifier.
  afs_if.host              link
);

  ////////////////////////////////////////////////////////////////////////////
  // APB decode.

  logic        setup;
  logic        done_acc;
  logic        wr_cmd;
  logic        rd_istat;
  logic        refuse;
  logic        busy_reg;
  logic        req_reg;
  logic        we_reg;
  logic [7:0]  addr_reg;
  logic [7:0]  wdata_reg;
  logic [7:0]  last_rd_reg;
  logic        sd_reg;
  logic [2:0]  istat_reg;
  logic [2:0]  imask_reg;
  logic [2:0]  events;
  logic [7:0]  cmd_addr;
  logic [31:0] rd_word;

  assign setup    = psel && !penable;
  assign done_acc = psel && penable && pready;
  assign wr_cmd   = done_acc && pwrite && (paddr == afs_pkg::H_CMD_ADDR);
  assign rd_istat = done_acc && !pwrite && (paddr == afs_pkg::H_ISTAT_ADDR);
  assign cmd_addr = pwdata[15:8];
  assign refuse   = (cmd_addr >= afs_pkg::RSVD_LO_ADDR) &&
                    (cmd_addr <= afs_pkg::RSVD_HI_ADDR);

  always_comb begin
    unique case (paddr)
      afs_pkg::H_STAT_ADDR:  rd_word = {23'h0, busy_reg, last_rd_reg};
      afs_pkg::H_PIN_ADDR:   rd_word = {31'h0, sd_reg};
      afs_pkg::H_ISTAT_ADDR: rd_word = {29'h0, istat_reg};
      afs_pkg::H_IMASK_ADDR: rd_word = {29'h0, imask_reg};
      default:               rd_word = 32'h0;
    endcase
  end

  // No wait state: data and ready are registered in the setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
    end else if (pclk_en) begin
      pready <= setup;
      prdata <= setup ? rd_word : 32'h0;
    end
  end

  assign pslverr = 1'b0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sd_reg    <= afs_pkg::SD_PIN_RESET;
      imask_reg <= 3'h0;
    end else if (pclk_en && done_acc && pwrite) begin
      if (paddr == afs_pkg::H_PIN_ADDR) begin
        sd_reg <= pwdata[0];
      end
      if (paddr == afs_pkg::H_IMASK_ADDR) begin
        imask_reg <= pwdata[2:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link commands.

  // Commands written while busy are dropped; software polls the busy bit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_reg   <= 1'b0;
      busy_reg  <= 1'b0;
      we_reg    <= 1'b0;
      addr_reg  <= 8'h00;
      wdata_reg <= 8'h00;
    end else if (pclk_en) begin
      req_reg <= 1'b0;
      if (wr_cmd && !busy_reg && !refuse) begin
        req_reg  <= 1'b1;
        busy_reg <= 1'b1;
        we_reg   <= pwdata[afs_pkg::CMD_WRITE_BIT];
        addr_reg <= cmd_addr;
        if (cmd_addr == afs_pkg::FAULT_ADDR) begin
          wdata_reg <= pwdata[7:0] & afs_pkg::FAULT_WR_MASK;
        end else begin
          wdata_reg <= pwdata[7:0];
        end
      end else if (link.ctl_ack) begin
        busy_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_rd_reg <= 8'h00;
    end else if (pclk_en && link.ctl_ack && !we_reg) begin
      last_rd_reg <= link.ctl_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts.

  always_comb begin
    events                      = 3'h0;
    events[afs_pkg::EV_DONE]    = link.ctl_ack;
    events[afs_pkg::EV_REFUSED] = wr_cmd && !busy_reg && refuse;
    events[afs_pkg::EV_FAULT]   = link.ctl_ack && !we_reg &&
                                  (addr_reg == afs_pkg::FAULT_ADDR) &&
                                  (link.ctl_rdata[3:0] != 4'h0);
  end

  // A new event in the clearing read survives it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_reg <= 3'h0;
      irq_o     <= 1'b0;
    end else if (pclk_en) begin
      istat_reg <= (rd_istat ? 3'h0 : istat_reg) | events;
      irq_o     <= |(((rd_istat ? 3'h0 : istat_reg) | events) & imask_reg);
    end
  end

  assign link.ctl_req            = req_reg;
  assign link.ctl_we             = we_reg;
  assign link.ctl_addr           = addr_reg;
  assign link.ctl_wdata          = wdata_reg;
  assign link.speaker_shutdown_n = sd_reg;

endmodule
`default_nettype wire

// *** logic/afs_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface afs_if;
  logic       ctl_req;
  logic       ctl_we;
  logic [7:0] ctl_addr;
  logic [7:0] ctl_wdata;
  logic       ctl_ack;
  logic [7:0] ctl_rdata;
  logic       speaker_shutdown_n;

  modport device (
    input  ctl_req,
    input  ctl_we,
    input  ctl_addr,
    input  ctl_wdata,
    input  speaker_shutdown_n,
    output ctl_ack,
    output ctl_rdata
  );
  modport host (
    output ctl_req,
    output ctl_we,
    output ctl_addr,
    output ctl_wdata,
    output speaker_shutdown_n,
    input  ctl_ack,
    input  ctl_rdata
  );
endinterface
`default_nettype wire

// *** logic/afs_pkg.sv ***
`default_nettype none
package afs_pkg;
  // Control port map of the amplifier (byte offsets on the link).
  localparam logic [7:0] CTRL_ADDR      = 8'h01;
  localparam logic [7:0] FAULT_ADDR     = 8'h08;
  localparam logic [7:0] RSVD_LO_ADDR   = 8'h09;
  localparam logic [7:0] RSVD_HI_ADDR   = 8'h0f;
  // Fault register layout.
  localparam int         SCALE_LSB      = 4;
  localparam int         CLK_FAULT_BIT  = 3;
  localparam int         OC_FAULT_BIT   = 2;
  localparam int         DC_FAULT_BIT   = 1;
  localparam int         OT_FAULT_BIT   = 0;
  localparam logic [7:0] FAULT_WR_MASK  = 8'h30;
  localparam logic [1:0] SCALE_RESET    = 2'h0;
  localparam logic [1:0] SCALE_FULL     = 2'h0;
  localparam logic [1:0] SCALE_75       = 2'h1;
  localparam logic [1:0] SCALE_50       = 2'h2;
  localparam logic [1:0] SCALE_25       = 2'h3;
  // Control register: bit 0 high lets the amplifier run.
  localparam int         RUN_BIT        = 0;
  localparam logic       RUN_RESET      = 1'b1;
  // Host APB register map (byte addresses).
  localparam logic [7:0] H_CMD_ADDR     = 8'h00;
  localparam logic [7:0] H_STAT_ADDR    = 8'h04;
  localparam logic [7:0] H_PIN_ADDR     = 8'h08;
  localparam logic [7:0] H_ISTAT_ADDR   = 8'h0c;
  localparam logic [7:0] H_IMASK_ADDR   = 8'h10;
  localparam int         CMD_WRITE_BIT  = 16;
  localparam int         STAT_BUSY_BIT  = 8;
  localparam int         EV_DONE        = 0;
  localparam int         EV_REFUSED     = 1;
  localparam int         EV_FAULT       = 2;
  localparam int         NUM_EV         = 3;
  localparam logic       SD_PIN_RESET   = 1'b0;
endpackage
`default_nettype wire
